// ===== timer2_defines.svh
// register offsets, bit positions, reset values and limits of the reload/capture timer
`ifndef TIMER2_DEFINES_SVH
`define TIMER2_DEFINES_SVH
`define ADDR_TIMER_CONTROL 8'hC8
`define ADDR_TIMER_MODE_CONTROL 8'hC9
`define ADDR_RELOAD_CAPTURE_LOW 8'hCA
`define ADDR_RELOAD_CAPTURE_HIGH 8'hCB
`define ADDR_COUNT_LOW_BYTE 8'hCC
`define ADDR_COUNT_HIGH_BYTE 8'hCD
`define ADDR_PRESCALE 8'hCE
`define BIT_OVERFLOW_FLAG 7
`define BIT_EXTERNAL_EDGE_FLAG 6
`define BIT_RX_CLOCK_SELECT 5
`define BIT_TX_CLOCK_SELECT 4
`define BIT_EXT_INPUT_ENABLE 3
`define BIT_RUN_CONTROL 2
`define BIT_COUNTER_SELECT 1
`define BIT_CAPTURE_SELECT 0
`define BIT_PIN_TOGGLE_ENABLE 1
`define BIT_DOWN_COUNT_ENABLE 0
`define RESET_CONTROL 8'h00
`define RESET_MODE 8'h00
`define RESET_WORD 16'h0000
`define COUNT_MIN 16'h0000
`define COUNT_MAX 16'hFFFF
`define RESET_PRESCALE 4'h0
`endif

// ===== timer2_pkg.sv
// types shared by the reload/capture timer
package timer2_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_RELOAD = 3'b001,
    MODE_UPDOWN = 3'b010,
    MODE_CAPTURE = 3'b011,
    MODE_BAUD = 3'b100,
    MODE_FREQ = 3'b101
  } mode_type;
endpackage

// ===== edge_sampler.sv
// two-sample falling edge detector for a pin
`timescale 1ns/1ps
module edge_sampler (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pin and result
  input wire logic pin,
  output logic fall,
  output logic level
);
  logic prev_ff;
  logic cur_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      cur_ff <= pin;
      prev_ff <= cur_ff;
    end
  end

  // high in one sample, low in the next
  assign fall = prev_ff & ~cur_ff;
  assign level = cur_ff;
endmodule

// ===== timer2_core.sv
// 16-bit timer/counter with reload/capture register
//
// Behaviour
// [R01] timer function counts once per clock, gated by the prescaler
// [R02] prescale divides count rate by 1 up to 16
// [R03] counter function samples count pin each clock, counts on high-then-low
// [R04] new count visible the cycle after edge detection, max half clock rate
// [R05] count source holds each level at least one full clock
// [R06] mode: off, baud, frequency, capture, else reload or up/down
// [R07] min 0000h, max ffffh, reload base is reload high and low joined
// [R08] count high and low bytes at cdh and cch
// [R09] reload/capture high and low bytes at cbh and cah
// [R10] overflow flag bit 7 sticky, never set while a serial clock select set
// [R11] external edge flag bit 6 set by enabled trigger capture or reload
// [R12] edge flag requests interrupt except when down count enable set
// [R13] rx clock select bit 5 routes overflow pulses to uart receive clock
// [R14] tx clock select bit 4 routes overflow pulses to uart transmit clock
// [R15] ext input enable bit 3 allows trigger capture/reload unless clocking serial
// [R16] run control bit 2 runs or stops the timer
// [R17] counter select bit 1: timer when 0, event counter when 1
// [R18] capture select bit 0: capture on trigger, else reload on overflow and trigger
// [R19] serial clock select forces auto-reload on overflow
// [R20] pin toggle enable with timer function toggles count pin per overflow
// [R21] down count enable with ext enable makes trigger pin set direction
// [R22] control and mode registers reset to zero
// [R23] capture copies count bytes into reload bytes on enabled trigger edge
// [R24] up/down: up reloads base after max, down reloads max at base
// [R25] up/down toggles edge flag on every overflow or underflow
// [R26] trigger pin edges found with the same two-sample method
`timescale 1ns/1ps
`include "timer2_defines.svh"
module timer2_core #(
  parameter int PRESCALE_BITS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic count_input_pin_in,
  output logic count_input_pin_out,
  output logic count_input_pin_oe,
  input wire logic trigger_pin,
  // uart clock and interrupt request
  output logic uart_rx_clock,
  output logic uart_tx_clock,
  output logic uart_rx_use_timer,
  output logic uart_tx_use_timer,
  output logic timer_irq_request,
  input wire logic timer_irq_enable
);
  // prescale register, its read-back and the reset value are laid out for a 4-bit field
  if (PRESCALE_BITS != 4) begin : bad_prescale_bits
    $error("prescale field must be 4 bits");
  end


  // ************************************************************
  // registers and decode
  // ************************************************************
  logic [7:0] control_ff;
  logic [7:0] mode_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic [PRESCALE_BITS-1:0] prescale_ff;
  logic [PRESCALE_BITS-1:0] prediv_ff;
  logic toggle_ff;
  logic [7:0] reg_rdata_ff;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  logic wr_control;
  logic wr_mode;
  logic wr_rl;
  logic wr_rh;
  logic wr_cl;
  logic wr_ch;
  logic wr_pre;
  assign wr_control = reg_write & hit(reg_addr, `ADDR_TIMER_CONTROL);
  assign wr_mode = reg_write & hit(reg_addr, `ADDR_TIMER_MODE_CONTROL);
  assign wr_rl = reg_write & hit(reg_addr, `ADDR_RELOAD_CAPTURE_LOW); // [R09]
  assign wr_rh = reg_write & hit(reg_addr, `ADDR_RELOAD_CAPTURE_HIGH); // [R09]
  assign wr_cl = reg_write & hit(reg_addr, `ADDR_COUNT_LOW_BYTE); // [R08]
  assign wr_ch = reg_write & hit(reg_addr, `ADDR_COUNT_HIGH_BYTE); // [R08]
  assign wr_pre = reg_write & hit(reg_addr, `ADDR_PRESCALE);

  // ************************************************************
  // control fields
  // ************************************************************
  logic overflow_flag;
  logic external_edge_flag;
  logic rx_clock_select;
  logic tx_clock_select;
  logic ext_input_enable;
  logic run_control;
  logic counter_select;
  logic capture_select;
  logic pin_toggle_enable;
  logic down_count_enable;
  logic serial_clock;
  assign overflow_flag = control_ff[`BIT_OVERFLOW_FLAG];
  assign external_edge_flag = control_ff[`BIT_EXTERNAL_EDGE_FLAG];
  assign rx_clock_select = control_ff[`BIT_RX_CLOCK_SELECT];
  assign tx_clock_select = control_ff[`BIT_TX_CLOCK_SELECT];
  assign ext_input_enable = control_ff[`BIT_EXT_INPUT_ENABLE];
  assign run_control = control_ff[`BIT_RUN_CONTROL];
  assign counter_select = control_ff[`BIT_COUNTER_SELECT];
  assign capture_select = control_ff[`BIT_CAPTURE_SELECT];
  assign pin_toggle_enable = mode_ff[`BIT_PIN_TOGGLE_ENABLE];
  assign down_count_enable = mode_ff[`BIT_DOWN_COUNT_ENABLE];
  assign serial_clock = rx_clock_select | tx_clock_select;

  // mode summary for the counting logic
  timer2_pkg::mode_type mode;
  always_comb begin
    if (!run_control) begin
      mode = timer2_pkg::MODE_OFF; // [R06] [R16]
    end else if (serial_clock) begin
      mode = timer2_pkg::MODE_BAUD; // [R06]
    end else if (pin_toggle_enable) begin
      mode = timer2_pkg::MODE_FREQ; // [R06]
    end else if (capture_select) begin
      mode = timer2_pkg::MODE_CAPTURE; // [R06]
    end else if (down_count_enable) begin
      mode = timer2_pkg::MODE_UPDOWN; // [R06]
    end else begin
      mode = timer2_pkg::MODE_RELOAD; // [R06]
    end
  end

  // ************************************************************
  // pin sampling
  // ************************************************************
  logic count_fall;
  logic trig_fall;
  logic trig_level;

  edge_sampler count_sampler (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(count_input_pin_in),
    .fall(count_fall), // [R03]
    .level()
  );

  edge_sampler trig_sampler (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(trigger_pin),
    .fall(trig_fall), // [R26]
    .level(trig_level)
  );

  // ************************************************************
  // count tick
  // ************************************************************
  logic pre_tick;
  assign pre_tick = (prediv_ff == prescale_ff); // [R02]

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prediv_ff <= '0;
    end else if (!run_control || pre_tick) begin
      prediv_ff <= '0;
    end else begin
      prediv_ff <= prediv_ff + 1'b1; // [R02]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_ff <= `RESET_PRESCALE;
    end else if (wr_pre) begin
      prescale_ff <= reg_wdata[PRESCALE_BITS-1:0];
    end
  end

  // timer ticks on prescaled clock, counter ticks on a sampled falling edge
  logic tick;
  assign tick = run_control & (counter_select ? count_fall : pre_tick); // [R01] [R03] [R17] [R16]

  // ************************************************************
  // next count and events
  // ************************************************************
  logic [15:0] base;
  logic count_down;
  logic at_top;
  logic at_reload_base;
  logic wrap;
  logic trig_event;
  logic do_capture;
  logic trig_reload;
  logic [15:0] nxt_count;
  assign base = reload_ff; // [R07]
  assign count_down = (mode == timer2_pkg::MODE_UPDOWN) & ext_input_enable & ~trig_level; // [R21] [R24]
  assign at_top = (count_ff == `COUNT_MAX); // [R07]
  assign at_reload_base = (count_ff == base);
  assign wrap = tick & (count_down ? at_reload_base : at_top);
  // enabled trigger edge, ignored as reload source while clocking serial
  assign trig_event = ext_input_enable & trig_fall; // [R15]
  assign do_capture = trig_event & run_control & capture_select & ~serial_clock
                      & ~pin_toggle_enable; // [R18] [R19]
  assign trig_reload = trig_event & ~capture_select & ~serial_clock
                       & ~(down_count_enable & ~pin_toggle_enable); // [R18] [R15]

  always_comb begin
    nxt_count = count_ff;
    if (wrap) begin
      if (count_down) begin
        nxt_count = `COUNT_MAX; // [R24]
      end else if (mode == timer2_pkg::MODE_CAPTURE) begin
        nxt_count = `COUNT_MIN; // [R07]
      end else begin
        nxt_count = base; // [R19] [R24] [R18]
      end
    end else if (tick) begin
      nxt_count = count_down ? count_ff - 16'h0001 : count_ff + 16'h0001; // [R04] [R24]
    end
    if (trig_reload && run_control) begin
      nxt_count = base; // [R18]
    end
  end

  // count register: software byte writes win over counting
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= `RESET_WORD;
    end else if (wr_cl) begin
      count_ff <= {count_ff[15:8], reg_wdata}; // [R08]
    end else if (wr_ch) begin
      count_ff <= {reg_wdata, count_ff[7:0]}; // [R08]
    end else begin
      count_ff <= nxt_count; // [R04]
    end
  end

  // capture beats a software write in the same cycle so the event is kept
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reload_ff <= `RESET_WORD;
    end else if (do_capture) begin
      reload_ff <= count_ff; // [R23]
    end else if (wr_rl) begin
      reload_ff <= {reload_ff[15:8], reg_wdata}; // [R09]
    end else if (wr_rh) begin
      reload_ff <= {reg_wdata, reload_ff[7:0]}; // [R09]
    end
  end

  // ************************************************************
  // control and mode registers
  // ************************************************************
  logic set_overflow;
  logic set_edge;
  logic toggle_edge;
  logic [7:0] nxt_control;
  assign set_overflow = wrap & ~serial_clock & ~pin_toggle_enable; // [R10]
  // in up/down the edge flag is a 17th count bit instead of an edge marker
  assign set_edge = trig_event & ~(down_count_enable & ~capture_select & ~serial_clock); // [R11]
  assign toggle_edge = wrap & (mode == timer2_pkg::MODE_UPDOWN); // [R25]

  always_comb begin
    nxt_control = control_ff;
    if (wr_control) begin
      nxt_control = reg_wdata;
    end
    // hardware set wins over a software clear in the same cycle
    if (set_overflow) begin
      nxt_control[`BIT_OVERFLOW_FLAG] = 1'b1; // [R10]
    end
    if (set_edge) begin
      nxt_control[`BIT_EXTERNAL_EDGE_FLAG] = 1'b1; // [R11]
    end else if (toggle_edge) begin
      nxt_control[`BIT_EXTERNAL_EDGE_FLAG] = ~control_ff[`BIT_EXTERNAL_EDGE_FLAG]; // [R25]
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_ff <= `RESET_CONTROL; // [R22]
    end else begin
      control_ff <= nxt_control;
    end
  end

  // only two mode bits exist; the rest read as zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= `RESET_MODE; // [R22]
    end else if (wr_mode) begin
      mode_ff <= {6'b00_0000, reg_wdata[1:0]};
    end
  end

  // ************************************************************
  // pin toggle and uart clocks
  // ************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_ff <= 1'b0;
    end else if (wrap && pin_toggle_enable && !counter_select) begin
      toggle_ff <= ~toggle_ff; // [R20]
    end
  end

  assign count_input_pin_out = toggle_ff;
  assign count_input_pin_oe = pin_toggle_enable & ~counter_select; // [R20]

  logic rx_clk_ff;
  logic tx_clk_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_clk_ff <= 1'b0;
      tx_clk_ff <= 1'b0;
    end else begin
      rx_clk_ff <= wrap & rx_clock_select; // [R13]
      tx_clk_ff <= wrap & tx_clock_select; // [R14]
    end
  end

  assign uart_rx_clock = rx_clk_ff;
  assign uart_tx_clock = tx_clk_ff;
  assign uart_rx_use_timer = rx_clock_select; // [R13]
  assign uart_tx_use_timer = tx_clock_select; // [R14]
  assign timer_irq_request = timer_irq_enable
                             & (overflow_flag | (external_edge_flag & ~down_count_enable)); // [R12]

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (!reg_read) begin
      reg_rdata_ff <= 8'h00;
    end else if (hit(reg_addr, `ADDR_TIMER_CONTROL)) begin
      reg_rdata_ff <= control_ff;
    end else if (hit(reg_addr, `ADDR_TIMER_MODE_CONTROL)) begin
      reg_rdata_ff <= mode_ff;
    end else if (hit(reg_addr, `ADDR_RELOAD_CAPTURE_LOW)) begin
      reg_rdata_ff <= reload_ff[7:0];
    end else if (hit(reg_addr, `ADDR_RELOAD_CAPTURE_HIGH)) begin
      reg_rdata_ff <= reload_ff[15:8];
    end else if (hit(reg_addr, `ADDR_COUNT_LOW_BYTE)) begin
      reg_rdata_ff <= count_ff[7:0];
    end else if (hit(reg_addr, `ADDR_COUNT_HIGH_BYTE)) begin
      reg_rdata_ff <= count_ff[15:8];
    end else if (hit(reg_addr, `ADDR_PRESCALE)) begin
      reg_rdata_ff <= {4'h0, prescale_ff};
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;
endmodule

// ===== pin_partner.sv
// far-side model: count pin source and trigger/direction pin
`timescale 1ns/1ps
module pin_partner (
  // clock
  input wire logic ref_clk,
  // levels asked for by the bench
  input wire logic count_req,
  input wire logic trig_req,
  // block's toggle driver
  input wire logic pin_out,
  input wire logic pin_oe,
  // pin levels seen by the block
  output logic count_pin,
  output logic trig_pin
);
  logic count_ff = 1'b1;
  logic trig_ff = 1'b1;
  // levels move only at edges, so each stands a whole cycle
  always @(posedge ref_clk) begin
    count_ff <= count_req;
    trig_ff <= trig_req;
  end
  // the block's driver wins the wire while enabled
  assign count_pin = pin_oe ? pin_out : count_ff;
  assign trig_pin = trig_ff;
endmodule

// ===== timer2_core_properties.sv
// port-level assertions for the reload/capture timer
`timescale 1ns/1ps
module timer2_core_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // pins and uart
  input wire logic count_input_pin_out,
  input wire logic count_input_pin_oe,
  input wire logic uart_rx_clock,
  input wire logic uart_rx_use_timer,
  input wire logic uart_tx_use_timer,
  input wire logic timer_irq_request,
  input wire logic timer_irq_enable
);
  logic tog_ff;
  logic down_count_enable_ff;
  logic cnt_ff;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // software-only bits shadowed from writes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tog_ff <= 1'b0;
      down_count_enable_ff <= 1'b0;
      cnt_ff <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == 8'hc8) cnt_ff <= reg_wdata[1];
      if (reg_addr == 8'hc9) tog_ff <= reg_wdata[1];
      if (reg_addr == 8'hc9) down_count_enable_ff <= reg_wdata[0];
    end
  end
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  rx_select_a: assert property ($past(reg_write && reg_addr == 8'hc8) |-> uart_rx_use_timer == $past(reg_wdata[5]))
    else $error("rx clock select not following write");
  tx_select_a: assert property ($past(reg_write && reg_addr == 8'hc8) |-> uart_tx_use_timer == $past(reg_wdata[4]))
    else $error("tx clock select not following write");
  rx_clock_gate_a: assert property (uart_rx_clock |-> $past(uart_rx_use_timer))
    else $error("rx clock pulse while not selected");
  irq_source_a: assert property (reg_read && reg_addr == 8'hc8 |=> $past(timer_irq_request) == ($past(timer_irq_enable)
    && (reg_rdata[7] || reg_rdata[6] && !$past(down_count_enable_ff))))
    else $error("interrupt request disagrees with flags");
  mode_readback_a: assert property (reg_read && reg_addr == 8'hc9 |=> reg_rdata[7:2] == 6'h00)
    else $error("unused mode bits read nonzero");
  pin_drive_a: assert property (count_input_pin_oe == (tog_ff && !cnt_ff))
    else $error("count pin driver enable wrong");
  toggle_source_a: assert property ($changed(count_input_pin_out) |-> $past(count_input_pin_oe))
    else $error("count pin toggled while not driving");
endmodule

// ===== timer2_core_tb.sv
// self-checking bench for the reload/capture timer
`timescale 1ns/1ps
module timer2_core_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic count_input_pin_in, count_input_pin_out, count_input_pin_oe, trigger_pin;
  logic uart_rx_clock, uart_tx_clock, uart_rx_use_timer, uart_tx_use_timer, timer_irq_request;
  logic timer_irq_enable = 1'b1;
  logic count_req = 1'b1;
  logic trig_req = 1'b1;
  logic rd_seen = 1'b0;
  logic prev_out = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic [15:0] base;
  logic [7:0] n;
  logic [31:0] seed = 32'h0000_ad5b;
  int n_errors = 0;
  int samples_checked = 0;
  int rx_pulses = 0;
  int toggles = 0;
  int tx_pulses = 0;
  timer2_core uut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .count_input_pin_in, .count_input_pin_out, .count_input_pin_oe, .trigger_pin, .uart_rx_clock,
    .uart_tx_clock, .uart_rx_use_timer, .uart_tx_use_timer, .timer_irq_request, .timer_irq_enable);
  pin_partner far (.ref_clk, .count_req, .trig_req, .pin_out(count_input_pin_out),
    .pin_oe(count_input_pin_oe), .count_pin(count_input_pin_in), .trig_pin(trigger_pin));
  initial forever #25 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ********
  // bus tasks and result watcher
  // ********
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask
  task pulse(input int k);
    repeat (k) begin
      @(posedge ref_clk) count_req <= 1'b0;
      @(posedge ref_clk) count_req <= 1'b1;
    end
    repeat (5) @(posedge ref_clk);
  endtask
  task trig(input logic v);
    @(posedge ref_clk) trig_req <= v;
    repeat (5) @(posedge ref_clk);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    rd_seen <= reg_read;
    timer_irq_enable <= seed[3];
    if (uart_rx_clock === 1'b1) rx_pulses++;
    if (uart_tx_clock === 1'b1) tx_pulses++;
    if (count_input_pin_out !== prev_out) toggles++;
    prev_out <= count_input_pin_out;
  end
  // read data stands only in the cycle after the strobe
  always @(negedge ref_clk) if (rd_seen) begin
    note = exp_q.pop_front();
    samples_checked++;
    if (reg_rdata !== note[7:0]) begin
      n_errors++;
      $display("Error reg %h expected %h seen %h", note[15:8], note[7:0], reg_rdata);
    end
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    $display("Error watchdog expired");
    end_of_test;
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'hc8, 8'h00);
    rd(8'hd0, 8'h00);
    wr(8'hc9, 8'hff);
    rd(8'hc9, 8'h03);
    wr(8'hc9, 8'h00);
    base = {1'b0, 15'(xs())};
    wr(8'hca, base[7:0]);
    wr(8'hcb, base[15:8]);
    rd(8'hca, base[7:0]);
    rd(8'hcb, base[15:8]);
    $display("register map done");
    // 24 counts from fff0: 16 reach the reload, 8 more from base
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hc8, 8'h04);
    repeat (20) @(posedge ref_clk);
    rd(8'hc8, 8'h84);
    wr(8'hc8, 8'h00);
    base = base + 16'h0008;
    rd(8'hcc, base[7:0]);
    rd(8'hcd, base[15:8]);
    rd(8'hc8, 8'h00);
    $display("timer reload done");
    void'(xs());
    n = 8'(seed[2:0]) + 8'h01;
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h06);
    pulse(n);
    rd(8'hcc, n);
    rd(8'hcd, 8'h00);
    wr(8'hc8, 8'h0f);
    trig(1'b0);
    rd(8'hca, n);
    rd(8'hcb, 8'h00);
    rd(8'hc8, 8'h4f);
    trig(1'b1);
    wr(8'hc8, 8'h0e);
    pulse(3);
    trig(1'b0);
    rd(8'hcc, n);
    rd(8'hc8, 8'h4e);
    $display("capture and trigger reload done");
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h01);
    wr(8'hc8, 8'h0e);
    pulse(1);
    rd(8'hcd, 8'hff);
    rd(8'hc8, 8'hce);
    trig(1'b1);
    pulse(1);
    rd(8'hcc, n);
    rd(8'hc8, 8'h8e);
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h00);
    $display("up down done");
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    // start one step below the top so overflows come every second cycle
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    rx_pulses = 0;
    tx_pulses = 0;
    wr(8'hc8, 8'h34);
    repeat (40) @(posedge ref_clk);
    rd(8'hc8, 8'h34);
    samples_checked++;
    if (rx_pulses < 10) begin
      n_errors++;
      $display("Error rx pulses expected 10 or more seen %0d", rx_pulses);
    end
    samples_checked++;
    if (tx_pulses < 10) begin
      n_errors++;
      $display("Error tx pulses expected 10 or more seen %0d", tx_pulses);
    end
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h02);
    toggles = 0;
    wr(8'hc8, 8'h04);
    repeat (40) @(posedge ref_clk);
    rd(8'hc8, 8'h04);
    samples_checked++;
    if (toggles < 10 || count_input_pin_oe !== 1'b1) begin
      n_errors++;
      $display("Error toggles expected 10 or more seen %0d", toggles);
    end
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h00);
    $display("baud and clock out done");
    // prescale n divides by n+1: ticks land every n+1 edges, 48 edges of run
    void'(xs());
    n = {4'h0, seed[3:0]};
    wr(8'hce, n);
    rd(8'hce, n);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h04);
    repeat (46) @(posedge ref_clk);
    wr(8'hc8, 8'h00);
    rd(8'hcc, 8'(48 / (int'(n) + 1)));
    rd(8'hcd, 8'h00);
    wr(8'hce, 8'h00);
    $display("prescale done");
    repeat (3) @(posedge ref_clk);
    end_of_test;
  end
endmodule
bind timer2_core timer2_core_checker chk (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .count_input_pin_out, .count_input_pin_oe, .uart_rx_clock, .uart_rx_use_timer,
  .uart_tx_use_timer, .timer_irq_request, .timer_irq_enable);
